// [verilog/plf_consts.vh]
// constants for the power indicator and shared pin select block
`ifndef PLF_CONSTS_VH
`define PLF_CONSTS_VH

// ==========================================================
// register byte offsets
`define PLF_OFF_SELECT 8'h00
`define PLF_OFF_STATUS 8'h04

// ==========================================================
// select register field positions
`define PLF_SEL_PIN_LSB 0
`define PLF_SEL_PIN_MSB 3
`define PLF_SEL_MAIN_LSB 4
`define PLF_SEL_MAIN_MSB 5
`define PLF_SEL_STBY_LSB 6
`define PLF_SEL_STBY_MSB 7
`define PLF_SEL_WIDTH 8

// ==========================================================
// reset values
`define PLF_RST_PIN_SEL 4'h0
`define PLF_RST_MODE 2'h0

// ==========================================================
// indicator mode encodings
`define PLF_MODE_LOW 2'h0
`define PLF_MODE_TRI 2'h1
`define PLF_MODE_HALF_HZ 2'h2
`define PLF_MODE_ONE_HZ 2'h3

// ==========================================================
// timing: clock rate and half period of the 1 Hz wave
`define PLF_CLK_HZ 100000000
`define PLF_HALF_PERIOD_1HZ_MS 500

// ==========================================================
// bus answers
`define PLF_RESP_OKAY 2'h0
`define PLF_RESP_SLVERR 2'h2

`endif

// [verilog/plf_blink.v]
// blink wave generator for the two indicator pins
`default_nettype none

module plf_blink #(
  parameter integer HALF_CYCLES = 50000000
) (
  // clock and reset
  input wire clk_sys,
  input wire rst_n,
  // waves
  output reg wave_1hz_q,
  output reg wave_half_hz_q
);

  reg [31:0] cnt_q;
  wire tick;

  assign tick = (cnt_q == HALF_CYCLES - 1);

  // ==========================================================
  // prescaler: one shared counter keeps both rates edge aligned
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 32'h00000000;
      wave_1hz_q <= 1'b0;
      wave_half_hz_q <= 1'b0;
    end else if (tick) begin
      cnt_q <= 32'h00000000;
      wave_1hz_q <= ~wave_1hz_q;
      // half rate toggles on every second 1 Hz toggle
      if (wave_1hz_q) begin
        wave_half_hz_q <= ~wave_half_hz_q;
      end
    end else begin
      cnt_q <= cnt_q + 32'h00000001;
    end
  end

endmodule // plf_blink

`default_nettype wire

// [verilog/plf_top.v]
// indicator drive modes and shared pin function select with AXI4-Lite registers
//
// What this block does
// - mode field 10 drives the main-domain indicator with a 0.5 Hz square wave.
// - mode field 11 drives the main-domain indicator with a 1 Hz square wave.
// - with both indicators blinking at the same rate, the main wave is the inverse of the standby wave.
// - select bit 3 gives the resume-reset pin to its function at 0, to general I/O at 1.
// - select bit 2 gives the power-good pin to its function at 0, to general I/O at 1.
// - select bit 1 gives the supply-on pin to its function at 0, to general I/O at 1.
// - select bit 0 gives the sleep-state pin to its function at 0, to general I/O at 1.
// - the four select bits are read/write and reset to 0, so pins start in their function.
// - mode field 00 holds the main-domain indicator low.
// - mode field 01 releases the main-domain indicator to high impedance.
`include "plf_consts.vh"
`default_nettype none

module plf_top #(
  parameter integer HALF_1HZ_CYCLES = (`PLF_CLK_HZ / 1000) * `PLF_HALF_PERIOD_1HZ_MS
) (
  // clock and reset
  input wire clk_sys,
  input wire rst_n,
  // axi4-lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // indicator pins
  output reg main_domain_indicator_out,
  output reg main_domain_indicator_oe,
  output reg standby_domain_indicator_out,
  output reg standby_domain_indicator_oe,
  // power sequencing drives, bit 0 sleep, 1 supply-on, 2 power-good, 3 resume-reset
  input wire seq_sleep_state_n,
  input wire seq_sleep_state_oe,
  input wire seq_supply_on_request_n,
  input wire seq_supply_on_request_oe,
  input wire seq_power_good_out,
  input wire seq_power_good_oe,
  input wire seq_resume_reset_n,
  input wire seq_resume_reset_oe,
  // general i/o side, bit 0 pin a .. bit 3 pin d
  input wire [3:0] gpio_out,
  input wire [3:0] gpio_oe,
  output reg [3:0] gpio_in,
  // power sequencing side sees the pin level while it owns the pin
  output reg [3:0] seq_pin_in,
  // shared pins
  input wire [3:0] shared_pin_in,
  output reg [3:0] shared_pin_out,
  output reg [3:0] shared_pin_oe
);

  // ==========================================================
  // decode helpers
  localparam [1:0] DEC_NONE = 2'h0;
  localparam [1:0] DEC_SELECT = 2'h1;
  localparam [1:0] DEC_STATUS = 2'h2;

  // word decode shared by the read and write paths
  function [1:0] reg_decode;
    input [7:0] addr;
    begin
      case ({addr[7:2], 2'b00})
        `PLF_OFF_SELECT: reg_decode = DEC_SELECT;
        `PLF_OFF_STATUS: reg_decode = DEC_STATUS;
        default: reg_decode = DEC_NONE;
      endcase
    end
  endfunction

  // mode to pin drive: {out, oe}
  function [1:0] mode_drive;
    input [1:0] mode;
    input wave_half;
    input wave_one;
    begin
      case (mode)
        `PLF_MODE_LOW: mode_drive = 2'b01;
        `PLF_MODE_TRI: mode_drive = 2'b00;
        `PLF_MODE_HALF_HZ: mode_drive = {wave_half, 1'b1};
        `PLF_MODE_ONE_HZ: mode_drive = {wave_one, 1'b1};
        default: mode_drive = 2'b00;
      endcase
    end
  endfunction

  // ==========================================================
  // state
  reg [3:0] pin_sel_q;
  reg [1:0] main_mode_q;
  reg [1:0] stby_mode_q;
  reg [7:0] awaddr_q;
  reg aw_got_q;
  reg [31:0] wdata_q;
  reg wstrb0_q;
  reg w_got_q;
  reg [3:0] pin_meta_q;
  reg [3:0] pin_sync_q;
  wire wave_1hz;
  wire wave_half_hz;
  wire [1:0] main_drive;
  wire [1:0] stby_drive;
  wire [3:0] seq_out;
  wire [3:0] seq_oe;
  wire [1:0] wr_dec;
  wire [1:0] rd_dec;
  wire do_write;
  wire [31:0] status_word;
  wire [3:0] pin_out_d;
  wire [3:0] pin_oe_d;
  wire [3:0] gpio_in_d;
  wire [3:0] seq_in_d;

  assign seq_out = {seq_resume_reset_n, seq_power_good_out,
                    seq_supply_on_request_n, seq_sleep_state_n};
  assign seq_oe = {seq_resume_reset_oe, seq_power_good_oe,
                   seq_supply_on_request_oe, seq_sleep_state_oe};

  // ==========================================================
  // blink source
  plf_blink #(
    .HALF_CYCLES(HALF_1HZ_CYCLES)
  ) u_blink (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wave_1hz_q(wave_1hz),
    .wave_half_hz_q(wave_half_hz)
  );

  // ==========================================================
  // indicator drive
  // standby takes the inverted wave so the pair alternates
  assign main_drive = mode_drive(main_mode_q, wave_half_hz, wave_1hz);
  assign stby_drive = mode_drive(stby_mode_q, ~wave_half_hz, ~wave_1hz);

  // registered so the pins never glitch on a mode write
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      main_domain_indicator_out <= 1'b0;
      main_domain_indicator_oe <= 1'b1;
      standby_domain_indicator_out <= 1'b0;
      standby_domain_indicator_oe <= 1'b1;
    end else begin
      main_domain_indicator_out <= main_drive[1];
      main_domain_indicator_oe <= main_drive[0];
      standby_domain_indicator_out <= stby_drive[1];
      standby_domain_indicator_oe <= stby_drive[0];
    end
  end

  // ==========================================================
  // shared pin input synchroniser, pins are asynchronous
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_q <= 4'h0;
      pin_sync_q <= 4'h0;
    end else begin
      pin_meta_q <= shared_pin_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  // ==========================================================
  // shared pin routing, one mux per pin
  // next values per pin, kept as nets so each output vector has one driver
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
      // general i/o owns the pin when its bit is set, sequencing drive is ignored
      assign pin_out_d[gi] = pin_sel_q[gi] ? gpio_out[gi] : seq_out[gi];
      assign pin_oe_d[gi] = pin_sel_q[gi] ? gpio_oe[gi] : seq_oe[gi];
      assign gpio_in_d[gi] = pin_sel_q[gi] & pin_sync_q[gi];
      assign seq_in_d[gi] = ~pin_sel_q[gi] & pin_sync_q[gi];
    end
  endgenerate

  // one register stage so every pin leaves a flip-flop
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      shared_pin_out <= 4'h0;
      shared_pin_oe <= 4'h0;
      gpio_in <= 4'h0;
      seq_pin_in <= 4'h0;
    end else begin
      shared_pin_out <= pin_out_d;
      shared_pin_oe <= pin_oe_d;
      gpio_in <= gpio_in_d;
      seq_pin_in <= seq_in_d;
    end
  end

  // ==========================================================
  // axi4-lite write path
  assign wr_dec = reg_decode(awaddr_q);
  assign do_write = aw_got_q && w_got_q && !s_axi_bvalid;

  // address and data taken in either order, answer after both
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PLF_RESP_OKAY;
      awaddr_q <= 8'h00;
      aw_got_q <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb0_q <= 1'b0;
      w_got_q <= 1'b0;
      pin_sel_q <= `PLF_RST_PIN_SEL;
      main_mode_q <= `PLF_RST_MODE;
      stby_mode_q <= `PLF_RST_MODE;
    end else begin
      if (s_axi_awready && s_axi_awvalid) begin
        awaddr_q <= s_axi_awaddr;
        aw_got_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wready && s_axi_wvalid) begin
        wdata_q <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
        w_got_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_dec == DEC_NONE) ? `PLF_RESP_SLVERR : `PLF_RESP_OKAY;
        // only the low byte lane carries fields
        if (wr_dec == DEC_SELECT && wstrb0_q) begin
          pin_sel_q <= wdata_q[`PLF_SEL_PIN_MSB:`PLF_SEL_PIN_LSB];
          main_mode_q <= wdata_q[`PLF_SEL_MAIN_MSB:`PLF_SEL_MAIN_LSB];
          stby_mode_q <= wdata_q[`PLF_SEL_STBY_MSB:`PLF_SEL_STBY_LSB];
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ==========================================================
  // axi4-lite read path
  assign rd_dec = reg_decode(s_axi_araddr);
  assign status_word = {26'h0000000, wave_1hz, wave_half_hz,
                        standby_domain_indicator_oe, standby_domain_indicator_out,
                        main_domain_indicator_oe, main_domain_indicator_out};

  // one read in flight; data captured at the address handshake
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `PLF_RESP_OKAY;
    end else begin
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        case (rd_dec)
          DEC_SELECT: begin
            s_axi_rdata <= {24'h000000, stby_mode_q, main_mode_q, pin_sel_q};
            s_axi_rresp <= `PLF_RESP_OKAY;
          end
          DEC_STATUS: begin
            s_axi_rdata <= status_word;
            s_axi_rresp <= `PLF_RESP_OKAY;
          end
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `PLF_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // plf_top

`default_nettype wire

// [testbench/plf_top_assertions.sv]
// checker for the indicator modes and shared pin routing
`default_nettype none
module plf_top_chk #(
  parameter integer HALF_1HZ_CYCLES = 4
) (
  // clock, reset and bus
  input wire logic clk_sys, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
  input wire logic s_axi_wready, s_axi_bvalid, s_axi_arvalid, s_axi_arready,
  input wire logic s_axi_rvalid, s_axi_rready,
  input wire logic [7:0] s_axi_awaddr, s_axi_araddr,
  input wire logic [31:0] s_axi_wdata, s_axi_rdata,
  input wire logic [3:0] s_axi_wstrb, gpio_oe, shared_pin_oe,
  input wire logic [1:0] s_axi_rresp,
  // pins
  input wire logic main_domain_indicator_out, main_domain_indicator_oe,
  input wire logic standby_domain_indicator_out, seq_sleep_state_oe,
  input wire logic seq_supply_on_request_oe, seq_power_good_oe, seq_resume_reset_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int H = HALF_1HZ_CYCLES;
  // ==========================================
  // shadow select byte, calm time, wave run length
  logic [7:0] sel_q;
  logic [3:0] eoe_q;
  logic prv_q;
  int qt_q, run_q;
  wire [1:0] md = sel_q[5:4];
  wire calm = qt_q > 5 * H; // mode must settle for a full slow period
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= 8'h00;
      eoe_q <= 4'h0;
      prv_q <= 1'b0;
      qt_q <= 0;
      run_q <= 0;
    end else begin
      qt_q <= (s_axi_awvalid && s_axi_awready) ? 0 : (qt_q < 999) ? qt_q + 1 : qt_q;
      if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
          && s_axi_awaddr[7:2] == 6'h00 && s_axi_wstrb[0]) sel_q <= s_axi_wdata[7:0];
      eoe_q <= (sel_q[3:0] & gpio_oe) | (~sel_q[3:0] & {seq_resume_reset_oe,
        seq_power_good_oe, seq_supply_on_request_oe, seq_sleep_state_oe});
      prv_q <= main_domain_indicator_out;
      run_q <= (main_domain_indicator_out != prv_q) ? 0 : run_q + 1;
    end
  end
  // ==========================================
  // properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_flip; main_domain_indicator_out != prv_q; endsequence
  sequence s_rtake; s_axi_arvalid && s_axi_arready; endsequence
  sequence s_wtake; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  a_pin_route: assert property (qt_q > 3 |-> shared_pin_oe == eoe_q)
    else $error("shared pin enable from wrong owner");
  a_main_low: assert property (calm && md == 2'h0 |->
    !main_domain_indicator_out && main_domain_indicator_oe) else $error("main not low");
  a_main_tri: assert property (calm && md == 2'h1 |-> !main_domain_indicator_oe)
    else $error("main not released");
  a_blink_one: assert property (calm && md == 2'h3 ##0 s_flip |-> run_q == H - 1)
    else $error("fast blink period wrong");
  a_blink_half: assert property (calm && md == 2'h2 ##0 s_flip |-> run_q == 2 * H - 1)
    else $error("slow blink period wrong");
  a_blink_anti: assert property (calm && md[1] && sel_q[7:6] == md |->
    main_domain_indicator_out != standby_domain_indicator_out) else $error("not antiphase");
  a_read_answer: assert property (s_rtake |=> s_axi_rvalid) else $error("read late");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  a_read_err: assert property (s_rtake ##0 s_axi_araddr[7:2] > 6'h01 |=> s_axi_rresp == 2'h2)
    else $error("unmapped read not refused");
  a_write_answer: assert property (s_wtake |-> ##[1:2] s_axi_bvalid) else $error("write late");
endmodule // plf_top_chk
bind plf_top plf_top_chk #(.HALF_1HZ_CYCLES(HALF_1HZ_CYCLES)) chk_i (.*);
`default_nettype wire

// [testbench/plf_top_tb.sv]
// self-checking bench for the indicator and shared pin select block
`default_nettype none
module plf_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int H = 4; // short blink half period for simulation
  logic clk_sys = 0, rst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, o;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 0, gpio_out = 0, gpio_oe = 0, shared_pin_in = 0, sv = 0, se = 0, s;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire main_domain_indicator_out, main_domain_indicator_oe;
  wire standby_domain_indicator_out, standby_domain_indicator_oe;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [3:0] gpio_in, seq_pin_in, shared_pin_out, shared_pin_oe;
  int errors = 0, checks = 0, n;
  logic [65:0] rq[$], nq;
  plf_top #(.HALF_1HZ_CYCLES(H)) uut (.*, .seq_sleep_state_n(sv[0]), .seq_sleep_state_oe(se[0]),
    .seq_supply_on_request_n(sv[1]), .seq_supply_on_request_oe(se[1]),
    .seq_power_good_out(sv[2]), .seq_power_good_oe(se[2]),
    .seq_resume_reset_n(sv[3]), .seq_resume_reset_oe(se[3]));
  // ==========================================
  // clock, watchdog, compare helpers
  always #5 clk_sys = ~clk_sys;
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    $display("Error watchdog expected end seen hang");
    complete_run();
  end
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ==========================================
  // bus master: an idle edge first so strobes never toggle twice in one step
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] st, logic [1:0] r);
    bit pa, pw, pb;
    @(posedge clk_sys);
    {pa, pw, pb} = 3'h7;
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, st};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (pb) begin
      @(posedge clk_sys);
      if (pa && s_axi_awready) begin
        pa = 0;
        s_axi_awvalid <= 0;
      end
      if (pw && s_axi_wready) begin
        pw = 0;
        s_axi_wvalid <= 0;
      end
      if (s_axi_bvalid) begin
        pb = 0;
        s_axi_bready <= 0;
        chk("bresp", r, s_axi_bresp);
      end
    end
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] m, logic [1:0] r);
    bit pa;
    @(posedge clk_sys);
    pa = 1;
    rq.push_back({m, e, r});
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do begin
      @(posedge clk_sys);
      if (pa && s_axi_arready) begin
        pa = 0;
        s_axi_arvalid <= 0;
      end
    end while (!s_axi_rvalid);
    s_axi_rready <= 0;
  endtask
  // read answers matched against the oldest note
  always @(posedge clk_sys) begin
    if (s_axi_rvalid && s_axi_rready) begin
      nq = rq.pop_front();
      chk("rdata", nq[33:2] & nq[65:34], s_axi_rdata & nq[65:34]);
      chk("rresp", 32'(nq[1:0]), 32'(s_axi_rresp));
    end
  end
  // ==========================================
  // tests
  initial begin
    void'($urandom(3));
    repeat (5) @(posedge clk_sys);
    rst_n <= 1;
    rd(8'h00, 0, 32'hFF, 2'h0);
    rd(8'h04, 32'hA, 32'hF, 2'h0);
    $display("reset test done");
    for (int i = 0; i < 16; i++) begin
      wr(8'h00, i, 4'h1, 2'h0);
      {sv, se, gpio_out, gpio_oe, shared_pin_in} <= 20'($urandom);
      repeat (5) @(posedge clk_sys);
      s = i[3:0];
      chk("pin_out", (s & gpio_out) | (~s & sv), shared_pin_out);
      chk("pin_oe", (s & gpio_oe) | (~s & se), shared_pin_oe);
      chk("gpio_in", shared_pin_in & s, gpio_in);
      chk("seq_in", shared_pin_in & ~s, seq_pin_in);
      rd(8'h00, i, 32'hF, 2'h0);
    end
    $display("pin routing test done");
    for (int m = 0; m < 4; m++) begin
      wr(8'h00, {m[1:0], m[1:0], 4'h0}, 4'h1, 2'h0);
      repeat (6 * H) @(posedge clk_sys);
      chk("main_oe", m != 1, main_domain_indicator_oe);
      if (m == 0) chk("main_out", 0, main_domain_indicator_out);
      if (m > 1) begin
        chk("antiphase", !standby_domain_indicator_out, main_domain_indicator_out);
        for (int k = 0; k < 2; k++) begin
          o = main_domain_indicator_out;
          n = 0;
          while (main_domain_indicator_out == o && n < 99) begin
            @(posedge clk_sys);
            n++;
          end
        end
        chk("half_period", (m == 3) ? H : 2 * H, n);
      end
      rd(8'h04, (m != 1) ? 32'hA : 32'h0, 32'hA, 2'h0);
    end
    $display("indicator mode test done");
    wr(8'h08, 32'hFF, 4'hF, 2'h2);
    rd(8'h08, 0, 32'hFFFFFFFF, 2'h2);
    wr(8'h00, 32'h5A, 4'h0, 2'h0);
    wr(8'h04, 32'hFF, 4'hF, 2'h0);
    rd(8'h00, 32'hF0, 32'hFF, 2'h0);
    $display("bus refusal test done");
    repeat (2) @(posedge clk_sys);
    complete_run();
  end
endmodule // plf_top_tb
`default_nettype wire
